// File: rtl/scm_pkg.sv
// Purpose: constants and types shared by the system clock manager
// Assumes: CLOCK is the system-rate reference, 25 MHz
// Notes: clocks leave the block as one-cycle enables and source gates
//
// Behaviour
// - system clock comes from exactly one source: 32MHz crystal or fast RC
// - fast RC nominal 27MHz uncalibrated, trimmable to about 32MHz
// - peripheral clock runs at half the system clock, 16MHz on crystal
// - timers may run from the undivided system clock instead
// - CPU and memory clock is a divided system clock
// - 32kHz domain selects internal RC, external crystal or external module
// - wake timers tick from 32kHz domain; sleep halts CPU until wake
// - 32kHz domain runs always and is calibrated against peripheral clock
// - after any reset the fast RC is the system source
// - switch to crystal automatically once stable, up to 1ms
// - CPU runs straight after reset on the RC clock
// - software can change the source and read which one is used
// - source query reads false once the crystal switch has completed
// - wake restarts on RC then auto-switches unless manual fast start chosen
// - CPU divider defaults to divide by two
// - CPU divider supports 1, 2, 4, 8, 16 and 32
package scm_pkg;

  localparam int unsigned CLOCK_HZ = 25_000_000;
  // crystal stabilisation bound, in microseconds
  localparam int unsigned XTAL_SETTLE_US = 1000;
  localparam int unsigned XTAL_SETTLE_CYCLES = (CLOCK_HZ / 1_000_000) * XTAL_SETTLE_US;
  // gap counter load for a handover; both source gates stay closed this many cycles plus one
  localparam logic [1:0] SWITCH_GAP_CYCLES = 2'h2;
  localparam logic [2:0] CPU_DIV_RESET = 3'h1;
  localparam logic [2:0] CPU_DIV_MAX = 3'h5;
  localparam logic [7:0] CAL_WINDOW_RESET = 8'h0A;

  typedef enum logic [4:0] {
    SCM_ST_RC       = 5'b0_0001,
    SCM_ST_GAP_XTAL = 5'b0_0010,
    SCM_ST_XTAL     = 5'b0_0100,
    SCM_ST_GAP_RC   = 5'b0_1000,
    SCM_ST_SLEEP    = 5'b1_0000
  } scm_state_t;

  typedef enum logic [1:0] {
    SCM_SLOW_RC   = 2'h0,
    SCM_SLOW_XTAL = 2'h1,
    SCM_SLOW_EXT  = 2'h2
  } scm_slow_src_t;

endpackage : scm_pkg

// File: rtl/scm_cpu_divider.sv
// Purpose: divides a system-rate enable by a power of two
// Assumes: tick_in is a one-cycle enable on CLOCK
// Notes: a new ratio takes effect at the next tick_in, compared at once with the running count
`timescale 1ns/100ps
`default_nettype none
module scm_cpu_divider
  import scm_pkg::*;
#(
  parameter int unsigned CNT_W = 5
) (
  input wire logic clk,            // system clock
  input wire logic rst_n,          // async reset, active low
  input wire logic tick_in,        // system-rate enable
  input wire logic [2:0] div_sel,  // log2 of division factor
  output logic tick_out            // divided enable
);

  initial begin
    if (CNT_W < 5) $error("scm_cpu_divider: CNT_W must be at least 5");
  end

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] limit;

  function automatic logic [CNT_W-1:0] ratio_limit(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > CPU_DIV_MAX) ? CPU_DIV_MAX : sel;
    ratio_limit = CNT_W'((32'h0000_0001 << s) - 32'h0000_0001);
  endfunction : ratio_limit

  always_comb begin
    limit = ratio_limit(div_sel);
    next_cnt = cnt;
    tick_out = 1'b0;
    if (tick_in) begin
      if (cnt >= limit) begin
        next_cnt = '0;
        tick_out = 1'b1;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule : scm_cpu_divider
`default_nettype wire

// File: rtl/scm_clock_manager.sv
// Purpose: system, peripheral, CPU and 32kHz clock management
// Assumes: oscillators sit outside; this block drives their gates and enables
// Notes: all derived rates are one-cycle enables on CLOCK
`timescale 1ns/100ps
`default_nettype none
module scm_clock_manager
  import scm_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = XTAL_SETTLE_CYCLES,
  parameter int unsigned CAL_W = 20
) (
  input wire logic CLOCK,               // 25 MHz system-rate clock
  input wire logic NRST,                // async reset, active low
  input wire logic XTAL_READY,          // crystal stable flag, asynchronous
  input wire logic SRC_SELECT_WR,       // system_clock_source_select strobe
  input wire logic SRC_SELECT_XTAL,     // requested source, 1 = crystal
  input wire logic FAST_START_MANUAL,   // wake_fast_start_option: stay on RC
  input wire logic [2:0] CPU_DIV_SEL,   // cpu_divider_select, log2 factor
  input wire logic TIMER_FAST,          // timers on undivided clock
  input wire logic SLEEP_REQ,           // enter sleep, one-cycle pulse
  input wire logic WAKE_EVENT,          // wake source level, asynchronous
  input wire logic SLOW_SRC_WR,         // 32kHz source select strobe
  input wire logic [1:0] SLOW_SRC_SEL,  // 32kHz source request
  input wire logic RC32K_CLK,           // internal 32kHz RC, asynchronous
  input wire logic XTAL32K_CLK,         // external 32kHz crystal, asynchronous
  input wire logic EXT32K_CLK,          // external 32kHz module, asynchronous
  input wire logic CAL_START,           // start 32kHz calibration, pulse
  input wire logic [7:0] CAL_WINDOW,    // 32kHz periods to measure
  output logic RC_GATE_EN,              // fast RC drives system clock
  output logic XTAL_GATE_EN,            // crystal drives system clock
  output logic XTAL_ENABLE,             // crystal oscillator power
  output logic SRC_IS_RC,               // system_clock_source_query
  output logic XTAL_TIMEOUT,            // crystal not ready within bound
  output logic CPU_RUN,                 // CPU not halted
  output logic PER_CLK_EN,              // peripheral clock enable
  output logic TIMER_CLK_EN,            // timer clock enable
  output logic CPU_CLK_EN,              // CPU clock enable
  output logic [1:0] SLOW_SRC,          // active 32kHz source
  output logic WAKE_TICK,               // 32kHz tick to wake timers
  output logic CAL_BUSY,                // calibration running
  output logic CAL_DONE,                // calibration result valid, pulse
  output logic [CAL_W-1:0] CAL_COUNT    // peripheral ticks in window
);

  initial begin
    if (CAL_W < 12) $error("scm_clock_manager: CAL_W too small");
    if (SETTLE_CYCLES < 1) $error("scm_clock_manager: SETTLE_CYCLES zero");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_prev;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_prev <= 5'h00;
    end else begin
      sync_a <= {EXT32K_CLK, XTAL32K_CLK, RC32K_CLK, WAKE_EVENT, XTAL_READY};
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end
  logic xtal_ok;
  logic wake_rise;
  assign xtal_ok = sync_b[0];
  assign wake_rise = sync_b[1] & ~sync_prev[1];

  // ----------------------------------------------------------------
  // system source selection
  // ----------------------------------------------------------------
  scm_state_t state;
  scm_state_t next_state;
  logic want_xtal;
  logic next_want_xtal;
  logic manual_armed;
  logic next_manual_armed;
  logic [1:0] gap;
  logic [1:0] next_gap;
  logic [31:0] settle;
  logic [31:0] next_settle;
  logic timeout;
  logic next_timeout;

  always_comb begin
    next_state = state;
    next_want_xtal = want_xtal;
    next_manual_armed = manual_armed;
    next_gap = gap;
    next_settle = settle;
    next_timeout = timeout;
    if (SRC_SELECT_WR) begin
      next_want_xtal = SRC_SELECT_XTAL;
    end
    // latched before sleep, applied at wake
    if (SLEEP_REQ) begin
      next_manual_armed = FAST_START_MANUAL;
    end
    if (XTAL_ENABLE && !xtal_ok && settle < SETTLE_CYCLES) begin
      next_settle = settle + 32'h0000_0001;
    end else if (!XTAL_ENABLE) begin
      next_settle = 32'h0000_0000;
    end
    if (XTAL_ENABLE && !xtal_ok && settle >= SETTLE_CYCLES) begin
      next_timeout = 1'b1;
    end else if (xtal_ok || !XTAL_ENABLE) begin
      next_timeout = 1'b0;
    end
    case (state)
      SCM_ST_RC: begin
        if (SLEEP_REQ) begin
          next_state = SCM_ST_SLEEP;
        end else if (next_want_xtal && xtal_ok) begin
          next_state = SCM_ST_GAP_XTAL;
          next_gap = SWITCH_GAP_CYCLES;
        end
      end
      SCM_ST_GAP_XTAL: begin
        if (gap == 2'h0) begin
          next_state = SCM_ST_XTAL;
        end else begin
          next_gap = gap - 2'h1;
        end
      end
      SCM_ST_XTAL: begin
        if (SLEEP_REQ) begin
          next_state = SCM_ST_SLEEP;
        end else if (!next_want_xtal || !xtal_ok) begin
          next_state = SCM_ST_GAP_RC;
          next_gap = SWITCH_GAP_CYCLES;
        end
      end
      SCM_ST_GAP_RC: begin
        if (gap == 2'h0) begin
          next_state = SCM_ST_RC;
        end else begin
          next_gap = gap - 2'h1;
        end
      end
      SCM_ST_SLEEP: begin
        if (wake_rise) begin
          next_state = SCM_ST_RC;
          next_want_xtal = ~manual_armed;
        end
      end
      default: begin
        next_state = SCM_ST_RC;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state <= SCM_ST_RC;
      want_xtal <= 1'b1;
      manual_armed <= 1'b0;
      gap <= 2'h0;
      settle <= 32'h0000_0000;
      timeout <= 1'b0;
    end else begin
      state <= next_state;
      want_xtal <= next_want_xtal;
      manual_armed <= next_manual_armed;
      gap <= next_gap;
      settle <= next_settle;
      timeout <= next_timeout;
    end
  end

  // gates are one-hot or both closed, never both open
  // the fast RC rate and its trim stay in the oscillator; here it is only gated
  assign RC_GATE_EN = (state == SCM_ST_RC);
  assign XTAL_GATE_EN = (state == SCM_ST_XTAL);
  // crystal is powered while awake only while it is the requested source
  assign XTAL_ENABLE = (state != SCM_ST_SLEEP) & want_xtal;
  assign SRC_IS_RC = (state != SCM_ST_XTAL);
  assign XTAL_TIMEOUT = timeout;
  assign CPU_RUN = (state != SCM_ST_SLEEP);

  // ----------------------------------------------------------------
  // derived clock enables
  // ----------------------------------------------------------------
  logic sys_tick;
  logic per_phase;
  logic next_per_phase;
  assign sys_tick = RC_GATE_EN | XTAL_GATE_EN;

  always_comb begin
    next_per_phase = per_phase;
    if (sys_tick) begin
      next_per_phase = ~per_phase;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      per_phase <= 1'b0;
    end else begin
      per_phase <= next_per_phase;
    end
  end

  assign PER_CLK_EN = sys_tick & per_phase;
  assign TIMER_CLK_EN = TIMER_FAST ? sys_tick : PER_CLK_EN;

  logic [2:0] cpu_div;
  logic [2:0] next_cpu_div;
  always_comb begin
    next_cpu_div = cpu_div;
    if (CPU_DIV_SEL != cpu_div) begin
      next_cpu_div = (CPU_DIV_SEL > CPU_DIV_MAX) ? CPU_DIV_MAX : CPU_DIV_SEL;
    end
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cpu_div <= CPU_DIV_RESET;
    end else begin
      cpu_div <= next_cpu_div;
    end
  end

  scm_cpu_divider #(
    .CNT_W(5)
  ) u_cpu_div (
    .clk(CLOCK),
    .rst_n(NRST),
    .tick_in(sys_tick),
    .div_sel(cpu_div),
    .tick_out(CPU_CLK_EN)
  );

  // ----------------------------------------------------------------
  // 32kHz domain
  // ----------------------------------------------------------------
  logic [1:0] slow_src;
  logic [1:0] next_slow_src;
  logic slow_edge;
  always_comb begin
    next_slow_src = slow_src;
    // once on an external source there is no way back to the RC
    if (SLOW_SRC_WR && SLOW_SRC_SEL != SCM_SLOW_RC && SLOW_SRC_SEL <= SCM_SLOW_EXT) begin
      next_slow_src = SLOW_SRC_SEL;
    end
    case (slow_src)
      SCM_SLOW_XTAL: slow_edge = sync_b[3] & ~sync_prev[3];
      SCM_SLOW_EXT: slow_edge = sync_b[4] & ~sync_prev[4];
      default: slow_edge = sync_b[2] & ~sync_prev[2];
    endcase
  end
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      slow_src <= SCM_SLOW_RC;
    end else begin
      slow_src <= next_slow_src;
    end
  end
  assign SLOW_SRC = slow_src;
  // keeps ticking in sleep and in normal running
  assign WAKE_TICK = slow_edge;

  // ----------------------------------------------------------------
  // calibration against the peripheral clock
  // ----------------------------------------------------------------
  logic cal_busy;
  logic next_cal_busy;
  logic cal_armed;
  logic next_cal_armed;
  logic [7:0] cal_left;
  logic [7:0] next_cal_left;
  logic [CAL_W-1:0] cal_acc;
  logic [CAL_W-1:0] next_cal_acc;
  logic [CAL_W-1:0] cal_count;
  logic [CAL_W-1:0] next_cal_count;
  logic cal_done;
  logic next_cal_done;

  always_comb begin
    next_cal_busy = cal_busy;
    next_cal_armed = cal_armed;
    next_cal_left = cal_left;
    next_cal_acc = cal_acc;
    next_cal_count = cal_count;
    next_cal_done = 1'b0;
    if (CAL_START && !cal_busy) begin
      next_cal_busy = 1'b1;
      next_cal_armed = 1'b0;
      next_cal_left = (CAL_WINDOW == 8'h00) ? CAL_WINDOW_RESET : CAL_WINDOW;
      next_cal_acc = '0;
    end else if (cal_busy) begin
      // window opens on a slow edge so the count covers whole periods
      if (!cal_armed) begin
        next_cal_armed = slow_edge;
      end else begin
        if (PER_CLK_EN) begin
          next_cal_acc = cal_acc + CAL_W'(1);
        end
        if (slow_edge) begin
          if (cal_left == 8'h01) begin
            next_cal_busy = 1'b0;
            next_cal_count = next_cal_acc;
            next_cal_done = 1'b1;
          end else begin
            next_cal_left = cal_left - 8'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      cal_busy <= 1'b0;
      cal_armed <= 1'b0;
      cal_left <= 8'h00;
      cal_acc <= '0;
      cal_count <= '0;
      cal_done <= 1'b0;
    end else begin
      cal_busy <= next_cal_busy;
      cal_armed <= next_cal_armed;
      cal_left <= next_cal_left;
      cal_acc <= next_cal_acc;
      cal_count <= next_cal_count;
      cal_done <= next_cal_done;
    end
  end

  assign CAL_BUSY = cal_busy;
  assign CAL_DONE = cal_done;
  assign CAL_COUNT = cal_count;

endmodule : scm_clock_manager
`default_nettype wire

// File: testbench/scm_clock_manager_asserts.sv
// Purpose: port-level checks for the clock manager
// Assumes: CLOCK is the only domain, NRST async active low
// Notes: bound to every scm_clock_manager instance
`timescale 1ns/100ps
`default_nettype none
module scm_clock_manager_asserts (
  input wire logic CLOCK, // system clock
  input wire logic NRST, // reset, active low
  input wire logic SLEEP_REQ, // sleep request
  input wire logic SLOW_SRC_WR, // 32k select strobe
  input wire logic [1:0] SLOW_SRC_SEL, // 32k select value
  input wire logic CAL_START, // calibration start
  input wire logic RC_GATE_EN, // rc gate
  input wire logic XTAL_GATE_EN, // crystal gate
  input wire logic XTAL_ENABLE, // crystal power
  input wire logic SRC_IS_RC, // source query
  input wire logic CPU_RUN, // cpu not halted
  input wire logic PER_CLK_EN, // peripheral enable
  input wire logic CPU_CLK_EN, // cpu enable
  input wire logic [1:0] SLOW_SRC, // active 32k source
  input wire logic CAL_BUSY, // calibration running
  input wire logic CAL_DONE // calibration done
);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  // three dead cycles keep a runt pulse off the derived enables
  sequence s_gap;
    !XTAL_GATE_EN [*3];
  endsequence
  sequence s_gap_rc;
    !RC_GATE_EN [*3];
  endsequence
  sequence s_cal_take;
    CAL_START && !CAL_BUSY;
  endsequence
  property p_one_src;
    !(RC_GATE_EN && XTAL_GATE_EN);
  endproperty
  a_one_src: assert property (p_one_src) else $error("both sources gated");
  property p_gap;
    $fell(RC_GATE_EN) && CPU_RUN |-> s_gap;
  endproperty
  a_gap: assert property (p_gap) else $error("handover gap too short");
  property p_gap_rc;
    $fell(XTAL_GATE_EN) && CPU_RUN |-> s_gap_rc;
  endproperty
  a_gap_rc: assert property (p_gap_rc) else $error("return gap too short");
  property p_query;
    XTAL_GATE_EN == !SRC_IS_RC;
  endproperty
  a_query: assert property (p_query) else $error("source query wrong");
  property p_per;
    PER_CLK_EN |=> !PER_CLK_EN;
  endproperty
  a_per: assert property (p_per) else $error("peripheral enable too fast");
  property p_sleep;
    SLEEP_REQ && (RC_GATE_EN || XTAL_GATE_EN) |=>
      !CPU_RUN && !RC_GATE_EN && !XTAL_GATE_EN && !XTAL_ENABLE;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_halt;
    !CPU_RUN |-> !CPU_CLK_EN && !PER_CLK_EN;
  endproperty
  a_halt: assert property (p_halt) else $error("enable while halted");
  property p_slow;
    SLOW_SRC_WR && (SLOW_SRC_SEL == 2'h1 || SLOW_SRC_SEL == 2'h2) |=>
      SLOW_SRC == $past(SLOW_SRC_SEL);
  endproperty
  a_slow: assert property (p_slow) else $error("32k source not taken");
  property p_cal_take;
    s_cal_take |=> CAL_BUSY;
  endproperty
  a_cal_take: assert property (p_cal_take) else $error("calibration not started");
  property p_cal_done;
    $fell(CAL_BUSY) |-> CAL_DONE;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("calibration end unflagged");
endmodule : scm_clock_manager_asserts
bind scm_clock_manager scm_clock_manager_asserts i_scm_clock_manager_asserts (
  .CLOCK(CLOCK), .NRST(NRST), .SLEEP_REQ(SLEEP_REQ), .SLOW_SRC_WR(SLOW_SRC_WR),
  .SLOW_SRC_SEL(SLOW_SRC_SEL), .CAL_START(CAL_START), .RC_GATE_EN(RC_GATE_EN),
  .XTAL_GATE_EN(XTAL_GATE_EN), .XTAL_ENABLE(XTAL_ENABLE), .SRC_IS_RC(SRC_IS_RC),
  .CPU_RUN(CPU_RUN), .PER_CLK_EN(PER_CLK_EN), .CPU_CLK_EN(CPU_CLK_EN),
  .SLOW_SRC(SLOW_SRC), .CAL_BUSY(CAL_BUSY), .CAL_DONE(CAL_DONE));
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: directed bench for the clock manager
// Assumes: crystal settle bound shortened to 20 cycles
// Notes: slow clocks come from one counter so their periods are exact
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scm_pkg::*;
  logic CLOCK, NRST, XTAL_READY, SRC_SELECT_WR, SRC_SELECT_XTAL, FAST_START_MANUAL;
  logic TIMER_FAST, SLEEP_REQ, WAKE_EVENT, SLOW_SRC_WR, CAL_START;
  logic RC32K_CLK, XTAL32K_CLK, EXT32K_CLK;
  logic [2:0] CPU_DIV_SEL;
  logic [1:0] SLOW_SRC_SEL, SLOW_SRC;
  logic [7:0] CAL_WINDOW;
  logic RC_GATE_EN, XTAL_GATE_EN, XTAL_ENABLE, SRC_IS_RC, XTAL_TIMEOUT, CPU_RUN;
  logic PER_CLK_EN, TIMER_CLK_EN, CPU_CLK_EN, WAKE_TICK, CAL_BUSY, CAL_DONE;
  logic [19:0] CAL_COUNT;
  logic [4:0] scnt = 5'h00;
  int fail_count = 0;
  int checks = 0;
  int k;
  int n;
  // periods of 32, 16 and 8 system cycles
  assign RC32K_CLK = scnt[4];
  assign XTAL32K_CLK = scnt[3];
  assign EXT32K_CLK = scnt[2];
  scm_clock_manager #(.SETTLE_CYCLES(20), .CAL_W(20)) i_scm_clock_manager (
    .CLOCK(CLOCK), .NRST(NRST), .XTAL_READY(XTAL_READY), .SRC_SELECT_WR(SRC_SELECT_WR),
    .SRC_SELECT_XTAL(SRC_SELECT_XTAL), .FAST_START_MANUAL(FAST_START_MANUAL),
    .CPU_DIV_SEL(CPU_DIV_SEL), .TIMER_FAST(TIMER_FAST), .SLEEP_REQ(SLEEP_REQ),
    .WAKE_EVENT(WAKE_EVENT), .SLOW_SRC_WR(SLOW_SRC_WR), .SLOW_SRC_SEL(SLOW_SRC_SEL),
    .RC32K_CLK(RC32K_CLK), .XTAL32K_CLK(XTAL32K_CLK), .EXT32K_CLK(EXT32K_CLK),
    .CAL_START(CAL_START), .CAL_WINDOW(CAL_WINDOW), .RC_GATE_EN(RC_GATE_EN),
    .XTAL_GATE_EN(XTAL_GATE_EN), .XTAL_ENABLE(XTAL_ENABLE), .SRC_IS_RC(SRC_IS_RC),
    .XTAL_TIMEOUT(XTAL_TIMEOUT), .CPU_RUN(CPU_RUN), .PER_CLK_EN(PER_CLK_EN),
    .TIMER_CLK_EN(TIMER_CLK_EN), .CPU_CLK_EN(CPU_CLK_EN), .SLOW_SRC(SLOW_SRC),
    .WAKE_TICK(WAKE_TICK), .CAL_BUSY(CAL_BUSY), .CAL_DONE(CAL_DONE),
    .CAL_COUNT(CAL_COUNT));
  // --------------------------------------------------------------
  // clock and helpers
  // --------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  always @(posedge CLOCK) begin
    scnt <= scnt + 5'h01;
  end
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic tick(input int t);
    repeat (t) @(posedge CLOCK);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // samples just after each edge so pulses of one cycle are all seen
  task automatic count(ref logic s, input int t, output int c);
    c = 0;
    repeat (t) begin
      tick(1);
      c += int'(s === 1'b1);
    end
  endtask : count
  task automatic wait_for(ref logic s, input logic v);
    int i;
    for (i = 0; i < 300 && s !== v; i++) tick(1);
    if (s !== v) begin
      fail_count++;
      $display("Error at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask : wait_for
  task automatic strobe(input int w);
    @(posedge CLOCK);
    case (w)
      0: SRC_SELECT_WR <= 1'b1;
      1: SLOW_SRC_WR <= 1'b1;
      2: SLEEP_REQ <= 1'b1;
      default: CAL_START <= 1'b1;
    endcase
    @(posedge CLOCK);
    {SRC_SELECT_WR, SLOW_SRC_WR, SLEEP_REQ, CAL_START} <= 4'h0;
    #1;
  endtask : strobe
  task automatic sel(input logic v);
    @(posedge CLOCK);
    SRC_SELECT_XTAL <= v;
    strobe(0);
  endtask : sel
  task automatic slow_src(input logic [1:0] v, input logic [1:0] exp, input int t);
    @(posedge CLOCK);
    SLOW_SRC_SEL <= v;
    strobe(1);
    tick(8);
    chk(SLOW_SRC, exp);
    count(WAKE_TICK, 128, k);
    chk(k, t);
  endtask : slow_src
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {NRST, XTAL_READY, SRC_SELECT_WR, SRC_SELECT_XTAL, FAST_START_MANUAL} = 5'h00;
    {TIMER_FAST, SLEEP_REQ, WAKE_EVENT, SLOW_SRC_WR, CAL_START} = 5'h00;
    CPU_DIV_SEL = 3'h1;
    SLOW_SRC_SEL = 2'h0;
    CAL_WINDOW = 8'h02;
    repeat (16) @(posedge CLOCK);
    NRST <= 1'b1;
    tick(1);
    chk(SRC_IS_RC, 1'b1);
    chk(RC_GATE_EN, 1'b1);
    chk(CPU_RUN, 1'b1);
    tick(28);
    chk(SRC_IS_RC, 1'b1);
    chk(XTAL_TIMEOUT, 1'b1);
    count(PER_CLK_EN, 40, k);
    chk(k, 20);
    @(posedge CLOCK);
    TIMER_FAST <= 1'b1;
    count(TIMER_CLK_EN, 40, k);
    chk(k, 40);
    @(posedge CLOCK);
    TIMER_FAST <= 1'b0;
    count(CPU_CLK_EN, 64, k);
    chk(k, 32);
    for (n = 0; n < 6; n++) begin
      @(posedge CLOCK);
      CPU_DIV_SEL <= 3'(n);
      tick(70);
      count(CPU_CLK_EN, 64, k);
      chk(k, 64 >> n);
    end
    // two slow periods of 32 cycles hold 32 peripheral ticks
    strobe(3);
    wait_for(CAL_DONE, 1'b1);
    chk(CAL_COUNT, 32'h20);
    chk(CAL_BUSY, 1'b0);
    count(WAKE_TICK, 128, k);
    chk(k, 4);
    slow_src(2'h2, 2'h2, 16);
    slow_src(2'h0, 2'h2, 16);
    slow_src(2'h1, 2'h1, 8);
    @(posedge CLOCK);
    XTAL_READY <= 1'b1;
    wait_for(SRC_IS_RC, 1'b0);
    chk(XTAL_GATE_EN, 1'b1);
    chk(RC_GATE_EN, 1'b0);
    sel(1'b0);
    // the query flips as the gap opens; the RC gate only after the gap
    wait_for(RC_GATE_EN, 1'b1);
    chk(SRC_IS_RC, 1'b1);
    sel(1'b1);
    wait_for(SRC_IS_RC, 1'b0);
    chk(XTAL_GATE_EN, 1'b1);
    // reset in mid-run while on the crystal
    @(posedge CLOCK);
    NRST <= 1'b0;
    tick(2);
    chk(RC_GATE_EN, 1'b1);
    @(posedge CLOCK);
    NRST <= 1'b1;
    tick(1);
    chk(SRC_IS_RC, 1'b1);
    wait_for(SRC_IS_RC, 1'b0);
    chk(XTAL_GATE_EN, 1'b1);
    for (n = 0; n < 2; n++) begin
      @(posedge CLOCK);
      FAST_START_MANUAL <= n[0];
      WAKE_EVENT <= 1'b0;
      strobe(2);
      chk(CPU_RUN, 1'b0);
      chk(XTAL_ENABLE, 1'b0);
      tick(8);
      @(posedge CLOCK);
      WAKE_EVENT <= 1'b1;
      wait_for(CPU_RUN, 1'b1);
      chk(SRC_IS_RC, 1'b1);
      tick(40);
      chk(SRC_IS_RC, n[0]);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
